/* design/tci_pkg.sv */
// constants, field layouts and helpers for the timer counter with input capture
package tci_pkg;

  // ****************************************************************
  // register offsets (byte addresses, one aligned word each)
  // ****************************************************************
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFS_CONTROL    = 8'h00;
  localparam logic [7:0]  OFS_COUNT_HIGH = 8'h04;
  localparam logic [7:0]  OFS_COUNT_LOW  = 8'h08;
  localparam logic [7:0]  OFS_MODULUS    = 8'h0C;
  localparam logic [7:0]  OFS_IRQ_STATUS = 8'h10;
  localparam logic [7:0]  OFS_IRQ_CLEAR  = 8'h14;
  localparam logic [7:0]  OFS_IRQ_ENABLE = 8'h18;
  localparam logic [7:0]  OFS_CH_BASE    = 8'h20;
  localparam logic [7:0]  CH_STRIDE      = 8'h10;
  localparam logic [7:0]  CH_SC          = 8'h00;
  localparam logic [7:0]  CH_VALUE_HIGH  = 8'h04;
  localparam logic [7:0]  CH_VALUE_LOW   = 8'h08;

  // ****************************************************************
  // field positions and encodings
  // ****************************************************************
  localparam int unsigned CTRL_CPWM_BIT  = 0;
  localparam int unsigned CTRL_RUN_BIT   = 1;
  localparam int unsigned STAT_OVF_BIT   = 0;
  localparam int unsigned STAT_CAP_LSB   = 1;
  localparam int unsigned SC_EDGE_LSB    = 0;
  localparam int unsigned SC_MODE_LSB    = 2;
  localparam logic [1:0]  EDGE_OFF       = 2'h0;
  localparam logic [1:0]  EDGE_RISE      = 2'h1;
  localparam logic [1:0]  EDGE_FALL      = 2'h2;
  localparam logic [1:0]  EDGE_ANY       = 2'h3;
  localparam logic [1:0]  MODE_CAPTURE   = 2'h0;
  localparam logic [1:0]  MODE_COMPARE   = 2'h1;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ****************************************************************
  // values after reset and counter limits
  // ****************************************************************
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [15:0] TERM_DEFAULT   = 16'hFFFF;
  localparam int unsigned NUM_CH_DEFAULT = 2;

  // terminal count from the modulus value
  function automatic logic [15:0] tci_term(input logic [15:0] modulusValue);
    tci_term = (modulusValue != COUNT_RESET) ? modulusValue : TERM_DEFAULT;
  endfunction : tci_term

  // byte address of a channel register
  function automatic logic [7:0] tci_ch_ofs(input int unsigned ch, input logic [7:0] sub);
    tci_ch_ofs = 8'(int'(OFS_CH_BASE) + int'(ch) * int'(CH_STRIDE) + int'(sub));
  endfunction : tci_ch_ofs

endpackage : tci_pkg

/* design/tci_edge_detect.sv */
// edge detector for one capture channel pin
`timescale 1ns/1ps
module tci_edge_detect
  import tci_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       clkEnable,
  input  wire logic       pin,
  input  wire logic [1:0] edgeSelect,
  output logic            edgeSeen
);
  import tci_pkg::*;

  typedef struct packed {
    logic pinPrev;
  } tci_edge_state_type;

  tci_edge_state_type st_q;
  tci_edge_state_type st_d;

  always_comb begin
    st_d = st_q;
    st_d.pinPrev = pin;
    unique case (edgeSelect)
      EDGE_RISE: edgeSeen = pin && !st_q.pinPrev;
      EDGE_FALL: edgeSeen = !pin && st_q.pinPrev;
      EDGE_ANY:  edgeSeen = pin != st_q.pinPrev;
      EDGE_OFF:  edgeSeen = 1'b0;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else if (clkEnable) begin
      st_q <= st_d;
    end
  end

  a_falling_only_sense: assert property (@(posedge clk) disable iff (reset)
    ($past(clkEnable) && edgeSelect == EDGE_FALL && edgeSeen) |-> (!pin && $past(pin)))
    else $error("falling edge select reported a non-falling edge");

endmodule : tci_edge_detect

/* design/tci_coherent_buf.sv */
// two-byte coherent read buffer for a 16-bit value
`timescale 1ns/1ps
module tci_coherent_buf
  import tci_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        clkEnable,
  input  wire logic [15:0] value,
  input  wire logic        readHigh,
  input  wire logic        readLow,
  input  wire logic        restart,
  output logic [7:0]       highByte,
  output logic [7:0]       lowByte,
  output logic             held
);
  import tci_pkg::*;

  typedef struct packed {
    logic        held;
    logic        hiDone;
    logic        loDone;
    logic [15:0] snap;
  } tci_buf_state_type;

  tci_buf_state_type st_q;
  tci_buf_state_type st_d;

  always_comb begin
    st_d = st_q;
    if (restart) begin
      st_d = '0;
    end else if (readHigh || readLow) begin
      if (!st_q.held) begin
        st_d.held   = 1'b1;
        st_d.snap   = value;
        st_d.hiDone = readHigh;
        st_d.loDone = readLow;
      end else begin
        st_d.hiDone = st_q.hiDone || readHigh;
        st_d.loDone = st_q.loDone || readLow;
      end
      if (st_d.hiDone && st_d.loDone) begin
        st_d = '0;
      end
    end
  end

  assign highByte = st_q.held ? st_q.snap[15:8] : value[15:8];
  assign lowByte  = st_q.held ? st_q.snap[7:0] : value[7:0];
  assign held     = st_q.held;

  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else if (clkEnable) begin
      st_q <= st_d;
    end
  end

  a_snapshot_stays_put: assert property (@(posedge clk) disable iff (reset)
    (st_q.held && !restart && !(readHigh && st_q.loDone) && !(readLow && st_q.hiDone))
    |=> (st_q.held && $stable(st_q.snap)))
    else $error("buffered value changed before both bytes were read");

  a_first_read_latch: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && !st_q.held && !restart && (readHigh ^ readLow))
    |=> (st_q.held && st_q.snap == $past(value)))
    else $error("first byte read did not latch the whole value");

endmodule : tci_coherent_buf

/* design/tci_timer_top.sv */
// timer counter with modulus, center-aligned counting, input capture and AXI4-Lite registers
`timescale 1ns/1ps
// Overview of operation
// - up mode counts from zero to terminal count, then wraps to zero
// - center mode counts up to terminal count, down to zero, then up again
// - in center mode zero and terminal count last one clock like others
// - enabled overflow flag drives a level interrupt; disabled means polling only
// - up mode sets overflow flag on passing terminal count to zero
// - center mode sets overflow flag on turning down from terminal count
// - reading either counter byte buffers both bytes for the other read
// - counter keeps running; buffered bytes stay until both are read
// - writing either counter byte zeroes counter and clears read buffer
// - without center mode, channel mode bits zero pick capture; compare and any other mode leave the channel value alone
// - active pin edge in capture mode copies counter into channel value
// - capture edge per channel is rising, falling or either
// - reading either channel value byte buffers both bytes coherently
// - writing channel status and control restarts its read buffer
module tci_timer_top
  import tci_pkg::*;
#(
  parameter int unsigned NUM_CH = NUM_CH_DEFAULT
) (
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  clkEnable,
  input  wire logic [ADDR_W-1:0]     awaddr,
  input  wire logic                  awvalid,
  output logic                       awready,
  input  wire logic [31:0]           wdata,
  input  wire logic [3:0]            wstrb,
  input  wire logic                  wvalid,
  output logic                       wready,
  output logic [1:0]                 bresp,
  output logic                       bvalid,
  input  wire logic                  bready,
  input  wire logic [ADDR_W-1:0]     araddr,
  input  wire logic                  arvalid,
  output logic                       arready,
  output logic [31:0]                rdata,
  output logic [1:0]                 rresp,
  output logic                       rvalid,
  input  wire logic                  rready,
  input  wire logic [NUM_CH-1:0]     channelPin,
  output logic                       irq
);
  import tci_pkg::*;

  localparam int unsigned SW = NUM_CH + 1;

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic                         awHave;
    logic                         awReady;
    logic [ADDR_W-1:0]            awAddr;
    logic                         wHave;
    logic                         wReady;
    logic [31:0]                  wData;
    logic [3:0]                   wStrb;
    logic                         bValid;
    logic [1:0]                   bResp;
    logic                         arReady;
    logic                         rValid;
    logic [31:0]                  rData;
    logic [1:0]                   rResp;
    logic                         cpwm;
    logic                         run;
    logic                         dirDown;
    logic [15:0]                  count;
    logic [15:0]                  modulus;
    logic [SW-1:0]                status;
    logic [SW-1:0]                enable;
    logic                         irq;
    logic [NUM_CH-1:0][3:0]       chSc;
    logic [NUM_CH-1:0][15:0]      chVal;
  } tci_top_state_type;

  tci_top_state_type st_q;
  tci_top_state_type st_d;

  logic              wrFire;
  logic              rdFire;
  logic              cntWrite;
  logic              cntReadHigh;
  logic              cntReadLow;
  logic              ovfEvent;
  logic [15:0]       term;
  logic [SW-1:0]     clearMask;
  logic [NUM_CH-1:0] scWrite;
  logic [NUM_CH-1:0] chReadHigh;
  logic [NUM_CH-1:0] chReadLow;
  logic [NUM_CH-1:0] capEvent;
  logic [NUM_CH-1:0] edgeSeen;
  logic [NUM_CH-1:0] chHeld;
  logic [NUM_CH-1:0][7:0] chHighByte;
  logic [NUM_CH-1:0][7:0] chLowByte;
  logic [7:0]        cntHighByte;
  logic [7:0]        cntLowByte;
  logic              cntHeld;

  // ****************************************************************
  // coherent read buffers and edge detectors
  // ****************************************************************
  tci_coherent_buf u_count_buf (
    .clk       (clk),
    .reset     (reset),
    .clkEnable (clkEnable),
    .value     (st_q.count),
    .readHigh  (cntReadHigh),
    .readLow   (cntReadLow),
    .restart   (cntWrite),
    .highByte  (cntHighByte),
    .lowByte   (cntLowByte),
    .held      (cntHeld)
  );

  for (genvar n = 0; n < NUM_CH; n++) begin : g_ch
    tci_edge_detect u_edge (
      .clk        (clk),
      .reset      (reset),
      .clkEnable  (clkEnable),
      .pin        (channelPin[n]),
      .edgeSelect (st_q.chSc[n][SC_EDGE_LSB +: 2]),
      .edgeSeen   (edgeSeen[n])
    );
    tci_coherent_buf u_val_buf (
      .clk       (clk),
      .reset     (reset),
      .clkEnable (clkEnable),
      .value     (st_q.chVal[n]),
      .readHigh  (chReadHigh[n]),
      .readLow   (chReadLow[n]),
      .restart   (scWrite[n]),
      .highByte  (chHighByte[n]),
      .lowByte   (chLowByte[n]),
      .held      (chHeld[n])
    );
  end

  // ****************************************************************
  // next state
  // ****************************************************************
  always_comb begin
    st_d        = st_q;
    term        = tci_term(st_q.modulus);
    wrFire      = st_q.awHave && st_q.wHave && !st_q.bValid;
    rdFire      = arvalid && st_q.arReady;
    cntWrite    = 1'b0;
    cntReadHigh = 1'b0;
    cntReadLow  = 1'b0;
    ovfEvent    = 1'b0;
    clearMask   = '0;
    scWrite     = '0;
    chReadHigh  = '0;
    chReadLow   = '0;
    capEvent    = '0;

    // write channel
    if (awvalid && st_q.awReady) begin
      st_d.awHave = 1'b1;
      st_d.awAddr = awaddr;
    end
    if (wvalid && st_q.wReady) begin
      st_d.wHave = 1'b1;
      st_d.wData = wdata;
      st_d.wStrb = wstrb;
    end
    if (st_q.bValid && bready) begin
      st_d.bValid = 1'b0;
    end
    if (wrFire) begin
      st_d.awHave = 1'b0;
      st_d.wHave  = 1'b0;
      st_d.bValid = 1'b1;
      st_d.bResp  = RESP_OKAY;
      if (st_q.awAddr == OFS_CONTROL) begin
        if (st_q.wStrb[0]) begin
          st_d.cpwm = st_q.wData[CTRL_CPWM_BIT];
          st_d.run  = st_q.wData[CTRL_RUN_BIT];
        end
      end else if (st_q.awAddr == OFS_COUNT_HIGH || st_q.awAddr == OFS_COUNT_LOW) begin
        cntWrite = st_q.wStrb != 4'h0;
      end else if (st_q.awAddr == OFS_MODULUS) begin
        if (st_q.wStrb[0]) begin
          st_d.modulus[7:0] = st_q.wData[7:0];
        end
        if (st_q.wStrb[1]) begin
          st_d.modulus[15:8] = st_q.wData[15:8];
        end
      end else if (st_q.awAddr == OFS_IRQ_CLEAR) begin
        if (st_q.wStrb[0]) begin
          clearMask = st_q.wData[SW-1:0];
        end
      end else if (st_q.awAddr == OFS_IRQ_ENABLE) begin
        if (st_q.wStrb[0]) begin
          st_d.enable = st_q.wData[SW-1:0];
        end
      end else if (st_q.awAddr != OFS_IRQ_STATUS) begin
        st_d.bResp = RESP_SLVERR;
        for (int unsigned i = 0; i < NUM_CH; i++) begin
          if (st_q.awAddr == tci_ch_ofs(i, CH_SC)) begin
            st_d.bResp = RESP_OKAY;
            if (st_q.wStrb[0]) begin
              st_d.chSc[i] = st_q.wData[3:0];
              scWrite[i]   = 1'b1;
            end
          end else if (st_q.awAddr == tci_ch_ofs(i, CH_VALUE_HIGH)
                    || st_q.awAddr == tci_ch_ofs(i, CH_VALUE_LOW)) begin
            st_d.bResp = RESP_OKAY;
          end
        end
      end
    end
    st_d.awReady = !st_d.awHave;
    st_d.wReady  = !st_d.wHave;

    // read channel
    if (st_q.rValid && rready) begin
      st_d.rValid = 1'b0;
    end
    if (rdFire) begin
      st_d.rValid = 1'b1;
      st_d.rResp  = RESP_OKAY;
      st_d.rData  = 32'h00000000;
      unique case (araddr)
        OFS_CONTROL: begin
          st_d.rData[CTRL_CPWM_BIT] = st_q.cpwm;
          st_d.rData[CTRL_RUN_BIT]  = st_q.run;
        end
        OFS_COUNT_HIGH: begin
          st_d.rData[7:0] = cntHighByte;
          cntReadHigh     = 1'b1;
        end
        OFS_COUNT_LOW: begin
          st_d.rData[7:0] = cntLowByte;
          cntReadLow      = 1'b1;
        end
        OFS_MODULUS:    st_d.rData[15:0] = st_q.modulus;
        OFS_IRQ_STATUS: st_d.rData[SW-1:0] = st_q.status;
        OFS_IRQ_ENABLE: st_d.rData[SW-1:0] = st_q.enable;
        OFS_IRQ_CLEAR:  st_d.rData = 32'h00000000;
        default: begin
          st_d.rResp = RESP_SLVERR;
          for (int unsigned i = 0; i < NUM_CH; i++) begin
            if (araddr == tci_ch_ofs(i, CH_SC)) begin
              st_d.rResp      = RESP_OKAY;
              st_d.rData[3:0] = st_q.chSc[i];
            end else if (araddr == tci_ch_ofs(i, CH_VALUE_HIGH)) begin
              st_d.rResp      = RESP_OKAY;
              st_d.rData[7:0] = chHighByte[i];
              chReadHigh[i]   = 1'b1;
            end else if (araddr == tci_ch_ofs(i, CH_VALUE_LOW)) begin
              st_d.rResp      = RESP_OKAY;
              st_d.rData[7:0] = chLowByte[i];
              chReadLow[i]    = 1'b1;
            end
          end
        end
      endcase
    end
    st_d.arReady = !st_d.rValid;

    // main counter
    if (cntWrite) begin
      st_d.count   = COUNT_RESET;
      st_d.dirDown = 1'b0;
    end else if (st_q.run) begin
      if (!st_q.cpwm) begin
        st_d.dirDown = 1'b0;
        if (st_q.count >= term) begin
          st_d.count = COUNT_RESET;
          ovfEvent   = 1'b1;
        end else begin
          st_d.count = st_q.count + 16'h0001;
        end
      end else if (!st_q.dirDown) begin
        if (st_q.count >= term) begin
          st_d.dirDown = 1'b1;
          st_d.count   = st_q.count - 16'h0001;
          ovfEvent     = 1'b1;
        end else begin
          st_d.count = st_q.count + 16'h0001;
        end
      end else begin
        if (st_q.count == COUNT_RESET) begin
          st_d.dirDown = 1'b0;
          st_d.count   = 16'h0001;
        end else begin
          st_d.count = st_q.count - 16'h0001;
        end
      end
    end

    // input capture
    for (int unsigned i = 0; i < NUM_CH; i++) begin
      capEvent[i] = edgeSeen[i] && !st_q.cpwm
                 && st_q.chSc[i][SC_MODE_LSB +: 2] == MODE_CAPTURE;
      if (capEvent[i]) begin
        st_d.chVal[i] = st_q.count;
      end
    end

    // sticky status, set wins over clear
    st_d.status = (st_q.status & ~clearMask)
                | {capEvent, ovfEvent};
    st_d.irq    = |(st_d.status & st_d.enable);
  end

  // ****************************************************************
  // registers and outputs
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (reset) begin
      st_q <= '0;
    end else if (clkEnable) begin
      st_q <= st_d;
    end
  end

  assign awready = st_q.awReady;
  assign wready  = st_q.wReady;
  assign bresp   = st_q.bResp;
  assign bvalid  = st_q.bValid;
  assign arready = st_q.arReady;
  assign rdata   = st_q.rData;
  assign rresp   = st_q.rResp;
  assign rvalid  = st_q.rValid;
  assign irq     = st_q.irq;

  // ****************************************************************
  // checks
  // ****************************************************************
  a_up_wrap_zero: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && st_q.run && !st_q.cpwm && !cntWrite && st_q.count == term)
    |=> (st_q.count == COUNT_RESET && st_q.status[STAT_OVF_BIT]))
    else $error("up count did not wrap to zero with overflow");

  a_center_turn_down: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && st_q.run && st_q.cpwm && !st_q.dirDown && !cntWrite && st_q.count == term)
    |=> (st_q.dirDown && st_q.count == $past(term) - 16'h0001))
    else $error("center count did not turn down at terminal count");

  a_center_zero_once: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && st_q.run && st_q.cpwm && st_q.dirDown && !cntWrite
     && st_q.count == COUNT_RESET) |=> (st_q.count == 16'h0001 && !st_q.dirDown))
    else $error("center count held zero for other than one clock");

  a_irq_follows_flag: assert property (@(posedge clk) disable iff (reset)
    (st_q.status[STAT_OVF_BIT] && st_q.enable[STAT_OVF_BIT]) |-> irq)
    else $error("enabled overflow flag without interrupt");

  a_irq_needs_cause: assert property (@(posedge clk) disable iff (reset)
    irq |-> |(st_q.status & st_q.enable))
    else $error("interrupt without an enabled status bit");

  a_center_ovf_turn: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && st_q.run && st_q.cpwm && st_q.dirDown && st_q.count != COUNT_RESET
     && clearMask[STAT_OVF_BIT] && !cntWrite) |=> !st_q.status[STAT_OVF_BIT])
    else $error("overflow set while counting down in center mode");

  a_count_write_zero: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && cntWrite) |=> (st_q.count == COUNT_RESET && !cntHeld))
    else $error("counter write did not zero count and buffer");

  a_count_step_one: assert property (@(posedge clk) disable iff (reset)
    (clkEnable && st_q.run && !st_q.cpwm && !cntWrite && st_q.count < term)
    |=> (st_q.count == $past(st_q.count) + 16'h0001))
    else $error("up count did not step by one");

  a_count_frozen_stop: assert property (@(posedge clk) disable iff (reset)
    (!st_q.run && !cntWrite) |=> $stable(st_q.count))
    else $error("counter moved while stopped");

  for (genvar n = 0; n < NUM_CH; n++) begin : g_chk
    a_capture_takes_count: assert property (@(posedge clk) disable iff (reset)
      (clkEnable && capEvent[n]) |=> (st_q.chVal[n] == $past(st_q.count)
                                      && st_q.status[STAT_CAP_LSB + n]))
      else $error("capture did not copy the counter");

    a_mode_blocks_capture: assert property (@(posedge clk) disable iff (reset)
      (st_q.cpwm || st_q.chSc[n][SC_MODE_LSB +: 2] != MODE_CAPTURE) |=> $stable(st_q.chVal[n]))
      else $error("channel value changed outside capture mode");

    a_sc_write_restart: assert property (@(posedge clk) disable iff (reset)
      (clkEnable && scWrite[n]) |=> !chHeld[n])
      else $error("control write left value buffer held");
  end

endmodule : tci_timer_top

/* sim/tci_event_src.sv */
// partner model: external event source on the capture pins
`timescale 1ns/1ps
module tci_event_src #(
  parameter int unsigned NUM_CH = 2
) (
  input  wire logic              clk,
  input  wire logic              reset,
  input  wire logic [NUM_CH-1:0] levelReq,
  output logic [NUM_CH-1:0]      channelPin
);
  // pins move one edge after a request, synchronous to the timer clock
  always @(posedge clk) begin
    if (reset) channelPin <= '0;
    else channelPin <= levelReq;
  end
endmodule : tci_event_src

/* sim/tb.sv */
// self-checking testbench for the timer counter
`timescale 1ns/1ps
`define CHK(x, y) begin total_checks++; if ((x) !== (y)) begin errors++; \
  $display("BAD %0t value mismatch", $time); end end
module tb;
  import tci_pkg::*;
  logic        clk, reset, awvalid, wvalid, arvalid, awready, wready, bvalid;
  logic        arready, rvalid, irq, clkEn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdv;
  logic [1:0]  bresp, rresp, rsp, pinReq, channelPin;
  logic [15:0] cnt, cntAfter;
  int          errors, total_checks;
  tci_timer_top u_dut (.clk, .reset, .clkEnable(clkEn), .awaddr, .awvalid, .awready,
    .wdata, .wstrb(4'hF), .wvalid, .wready, .bresp, .bvalid, .bready(1'b1), .araddr,
    .arvalid, .arready, .rdata, .rresp, .rvalid, .rready(1'b1), .channelPin, .irq);
  tci_event_src u_src (.clk, .reset, .levelReq(pinReq), .channelPin);
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
      n++;
      if (n > 100) begin errors++; give_verdict(); end
    end
    rsp = bresp;
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a;
    arvalid <= 1'b1;
    forever begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
      n++;
      if (n > 100) begin errors++; give_verdict(); end
    end
    rdv = rdata;
    rsp = rresp;
  endtask : axi_rd
  task automatic t_upcount;
    axi_wr(OFS_MODULUS, 32'h4);
    axi_wr(OFS_CONTROL, 32'h2);
    repeat (3) begin
      axi_rd(OFS_COUNT_LOW);
      `CHK(rdv <= 32'h4, 1'b1)
      axi_rd(OFS_COUNT_HIGH);
      `CHK(rdv, 32'h0)
    end
    axi_rd(OFS_IRQ_STATUS);
    `CHK(rdv[STAT_OVF_BIT], 1'b1)
    `CHK(irq, 1'b0)
    axi_wr(OFS_IRQ_ENABLE, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b1)
    axi_wr(OFS_CONTROL, 32'h0);
    axi_wr(OFS_IRQ_CLEAR, 32'h1);
    @(posedge clk);
    `CHK(irq, 1'b0)
    axi_rd(8'hFC);
    `CHK(rsp, RESP_SLVERR)
    $display("test upcount done");
  endtask : t_upcount
  task automatic t_coherent;
    axi_wr(OFS_MODULUS, 32'h0);
    axi_wr(OFS_COUNT_LOW, 32'h0);
    axi_wr(OFS_CONTROL, 32'h2);
    axi_rd(OFS_COUNT_LOW);
    repeat (300) @(posedge clk);
    axi_rd(OFS_COUNT_HIGH);
    `CHK(rdv, 32'h0)
    axi_rd(OFS_COUNT_LOW);
    axi_wr(OFS_COUNT_HIGH, 32'h5A);
    axi_rd(OFS_COUNT_HIGH);
    `CHK(rdv, 32'h0)
    axi_rd(OFS_COUNT_LOW);
    axi_rd(OFS_COUNT_LOW);
    cnt[7:0] = rdv[7:0];
    axi_rd(OFS_COUNT_HIGH);
    cnt[15:8] = rdv[7:0];
    clkEn <= 1'b0;
    repeat (50) @(posedge clk);
    clkEn <= 1'b1;
    axi_rd(OFS_COUNT_LOW);
    cntAfter[7:0] = rdv[7:0];
    axi_rd(OFS_COUNT_HIGH);
    cntAfter[15:8] = rdv[7:0];
    `CHK(cntAfter != cnt && cntAfter - cnt < 16'h0014, 1'b1)
    $display("test coherent done");
  endtask : t_coherent
  task automatic t_capture;
    logic [3:0] sel[5];
    logic       hit;
    sel = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h0};
    repeat (40) @(posedge clk);
    axi_wr(OFS_CONTROL, 32'h0);
    axi_rd(OFS_COUNT_LOW);
    cnt[7:0] = rdv[7:0];
    axi_rd(OFS_COUNT_HIGH);
    cnt[15:8] = rdv[7:0];
    foreach (sel[i]) begin
      axi_wr(tci_ch_ofs(0, CH_SC), {28'h0, sel[i]});
      repeat (2) begin
        axi_wr(OFS_IRQ_CLEAR, 32'h2);
        pinReq[0] <= ~pinReq[0];
        repeat (4) @(posedge clk);
        hit = sel[i][3:2] == MODE_CAPTURE && sel[i][1:0] != EDGE_OFF
              && (sel[i][1:0] == EDGE_ANY || (sel[i][1:0] == EDGE_RISE) == pinReq[0]);
        axi_rd(OFS_IRQ_STATUS);
        `CHK(rdv[STAT_CAP_LSB], hit)
      end
    end
    axi_wr(tci_ch_ofs(0, CH_SC), 32'h3);
    axi_rd(tci_ch_ofs(0, CH_VALUE_HIGH));
    `CHK(rdv[7:0], cnt[15:8])
    axi_wr(tci_ch_ofs(0, CH_SC), 32'h3);
    axi_wr(OFS_COUNT_LOW, 32'h0);
    pinReq[0] <= ~pinReq[0];
    repeat (4) @(posedge clk);
    axi_rd(tci_ch_ofs(0, CH_VALUE_LOW));
    `CHK(rdv[7:0], 8'h00)
    axi_rd(tci_ch_ofs(0, CH_VALUE_HIGH));
    `CHK(rdv[7:0], 8'h00)
    $display("test capture done");
  endtask : t_capture
  task automatic t_center;
    axi_wr(OFS_MODULUS, 32'h3);
    axi_wr(OFS_IRQ_CLEAR, 32'h1);
    axi_wr(OFS_COUNT_LOW, 32'h0);
    axi_wr(OFS_CONTROL, 32'h3);
    repeat (4) begin
      axi_rd(OFS_COUNT_LOW);
      `CHK(rdv <= 32'h3, 1'b1)
      axi_rd(OFS_COUNT_HIGH);
      `CHK(rdv, 32'h0)
    end
    axi_rd(OFS_IRQ_STATUS);
    `CHK(rdv[STAT_OVF_BIT], 1'b1)
    `CHK(irq, 1'b1)
    axi_wr(OFS_MODULUS, 32'h40);
    repeat (72) @(posedge clk);
    axi_wr(OFS_IRQ_CLEAR, 32'h1);
    axi_rd(OFS_IRQ_STATUS);
    `CHK(rdv[STAT_OVF_BIT], 1'b0)
    `CHK(irq, 1'b0)
    $display("test center done");
  endtask : t_center
  initial begin
    reset = 1'b1;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    pinReq = 2'h0;
    clkEn = 1'b1;
    errors = 0;
    total_checks = 0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    t_upcount();
    t_coherent();
    t_capture();
    t_center();
    give_verdict();
  end
endmodule : tb
